/* design/prlc_top.sv */
/*
 * prlc_top: write lock, unlock sequence, shadow monitor, input and
 * output map registers, analog pin default and pin ownership.
 * assumes one 40 MHz clock, synchronous reset, pins asynchronous.
 */
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - locked lock bit makes every map register write vanish silently
// - lock bit sits at bit 6 of the oscillator control register
// - lock changes only after key bytes 0x46 then 0x57, then one write
// - lock keeps its value until software changes it again
// - shadow copies of map registers compared always; mismatch asks reset
// - one-session strap forbids clearing the lock once it was set
// - one-session and locked: unlock sequence ignored, only reset frees it
// - one-session strap is active when left unprogrammed, high level
// - shared pins start analog; their digital reads return zero
// - highest priority enabled function owns a multi-function pin
// - fourteen input map registers and thirteen output map registers
// - input fields are 5 bits, reset all ones, 11111 ties input low
// - first input map register holds irq1 select in bits 12-8
// - second input map register holds irq2 select in bits 4-0
// - remapped input needs its direction bit set as input
// - output field 00000 leaves the pin on its port function
module prlc_top
    import prlc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // configuration strap and pins
    input wire logic one_session_lock_cfg,
    input wire logic [N_PINS-1:0] pin_in,
    // results
    output logic remap_write_lock,
    output logic cfg_mismatch_rst,
    output logic ext_irq1_in,
    output logic ext_irq2_in,
    output logic [N_PINS-1:0] pin_analog_own,
    output logic [N_PINS-1:0] pin_periph_own,
    output logic irq
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // implemented bits of each input map register
    // unimplemented bits are forced low so they always read as zero
    function automatic logic [15:0] in_mask(input int idx);
        if (idx == IN_IDX_IRQ1) begin
            return MASK_HI_FIELD;
        end else if (idx == IN_IDX_IRQ2 || idx == IN_IDX_LO_ONLY) begin
            return MASK_LO_FIELD;
        end
        return MASK_BOTH;
    endfunction

    // pick a pin for a remapped input; ground for 11111 and out of range
    // a pin set as output by its direction bit never reaches the input
    function automatic logic pick_pin(input logic [4:0] sel,
                                      input logic [N_PINS-1:0] dig,
                                      input logic [N_PINS-1:0] dir);
        if (sel > PIN_SEL_MAX) begin
            return 1'b0;
        end
        return dig[sel] & dir[sel];
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] in_map_q [N_IN_MAP];
    logic [15:0] in_shadow_q [N_IN_MAP];
    logic [15:0] out_map_q [N_OUT_MAP];
    logic [15:0] out_shadow_q [N_OUT_MAP];
    logic lock_q;
    logic one_sess_q;
    prlc_seq_t seq_q;
    prlc_seq_t seq_d;
    logic [N_EV-1:0] ev_stat_q;
    logic [N_EV-1:0] ev_en_q;
    logic [N_PINS-1:0] ana_cfg_q;
    logic [N_PINS-1:0] dir_q;
    logic [N_PINS-1:0] pin_meta_q;
    logic [N_PINS-1:0] pin_sync_q;
    logic cfg_meta_q;
    logic cfg_sync_q;
    logic [15:0] rdata_q;
    logic irq_q;
    logic mism_q;
    logic irq1_q;
    logic irq2_q;
    logic [N_PINS-1:0] ana_own_q;
    logic [N_PINS-1:0] per_own_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic wr_osc = reg_wr && reg_addr == A_OSC_CTL;
    wire logic [7:0] in_off = reg_addr - A_IN_MAP;
    wire logic [7:0] out_off = reg_addr - A_OUT_MAP;
    wire logic hit_in = reg_addr >= A_IN_MAP && in_off < 8'(N_IN_MAP);
    wire logic hit_out = reg_addr >= A_OUT_MAP && out_off < 8'(N_OUT_MAP);
    wire logic wr_map = reg_wr && (hit_in || hit_out);
    // map writes only land while unlocked, otherwise dropped silently
    // limitation: software sees no error, only the locked-write status bit
    wire logic map_we = wr_map && !lock_q;
    wire logic [7:0] osc_low = reg_wdata[7:0];
    wire logic new_lock = reg_wdata[LOCK_BIT];

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    // locked in one-session mode: the keys never arm anything
    // hazard avoided: a stray key pair cannot reopen a once-only lock
    wire logic seq_blocked = one_sess_q && lock_q;
    wire logic key1_ok = osc_low == KEY_FIRST;
    wire logic key2_ok = osc_low == KEY_SECOND;
    wire logic lock_upd = wr_osc && seq_q == PRLC_SEQ_ARMED && !seq_blocked;
    // a second key missing or a stray write ends the attempt
    wire logic seq_abort = wr_osc && seq_q == PRLC_SEQ_KEY1 && !key2_ok;

    // next state of the key sequence
    always_comb begin
        seq_d = seq_q;
        if (wr_osc) begin
            case (seq_q)
                PRLC_SEQ_IDLE: begin
                    seq_d = (key1_ok && !seq_blocked) ? PRLC_SEQ_KEY1 : PRLC_SEQ_IDLE;
                end
                PRLC_SEQ_KEY1: begin
                    seq_d = key2_ok ? PRLC_SEQ_ARMED : PRLC_SEQ_IDLE;
                end
                PRLC_SEQ_ARMED: begin
                    seq_d = PRLC_SEQ_IDLE;
                end
                default: begin
                    seq_d = PRLC_SEQ_IDLE;
                end
            endcase
        end
    end

    // sequence register and the lock itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seq_q <= PRLC_SEQ_IDLE;
            lock_q <= LOCK_RST;
        end else begin
            seq_q <= seq_d;
            if (lock_upd) begin
                lock_q <= new_lock;
            end
        end
    end

    // strap capture: sampled while reset is held, frozen afterwards
    // the strap is only trusted under reset, so a later glitch on it
    // cannot turn a once-only lock back into a reopenable one
    always_ff @(posedge ref_clk) begin
        cfg_meta_q <= one_session_lock_cfg;
        cfg_sync_q <= cfg_meta_q;
        if (rst) begin
            one_sess_q <= cfg_sync_q;
        end
    end

    // ------------------------------------------------------------
    // map registers with shadows
    // ------------------------------------------------------------
    // shadows load with the same write so only a disturbed cell differs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < N_IN_MAP; i++) begin
                in_map_q[i] <= in_mask(i);
                in_shadow_q[i] <= in_mask(i);
            end
            for (int j = 0; j < N_OUT_MAP; j++) begin
                out_map_q[j] <= OUT_MAP_RST;
                out_shadow_q[j] <= OUT_MAP_RST;
            end
        end else if (map_we) begin
            for (int i = 0; i < N_IN_MAP; i++) begin
                if (hit_in && in_off == 8'(i)) begin
                    in_map_q[i] <= reg_wdata & in_mask(i);
                    in_shadow_q[i] <= reg_wdata & in_mask(i);
                end
            end
            for (int j = 0; j < N_OUT_MAP; j++) begin
                if (hit_out && out_off == 8'(j)) begin
                    out_map_q[j] <= reg_wdata & MASK_BOTH;
                    out_shadow_q[j] <= reg_wdata & MASK_BOTH;
                end
            end
        end
    end

    // continuous compare of every map register against its shadow
    // both copies share one write strobe, so a difference means an upset
    // cell; the request stays up until reset or an unlocked write of that register rewrites both copies
    logic mism_any;
    always_comb begin
        mism_any = 1'b0;
        for (int i = 0; i < N_IN_MAP; i++) begin
            mism_any = mism_any | (in_map_q[i] != in_shadow_q[i]);
        end
        for (int j = 0; j < N_OUT_MAP; j++) begin
            mism_any = mism_any | (out_map_q[j] != out_shadow_q[j]);
        end
    end

    // ------------------------------------------------------------
    // analog default, direction, pin inputs
    // ------------------------------------------------------------
    // pins arrive asynchronously, two flops before use
    // trade-off: two cycles of pin latency against metastable reads
    always_ff @(posedge ref_clk) begin
        pin_meta_q <= pin_in;
        pin_sync_q <= pin_meta_q;
    end

    wire logic wr_ana_lo = reg_wr && reg_addr == A_ANA_LO;
    wire logic wr_ana_hi = reg_wr && reg_addr == A_ANA_HI;
    wire logic wr_dir_lo = reg_wr && reg_addr == A_DIR_LO;
    wire logic wr_dir_hi = reg_wr && reg_addr == A_DIR_HI;

    // software-owned pin configuration; analog and input after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ana_cfg_q <= ANA_CFG_RST;
            dir_q <= DIR_RST;
        end else begin
            if (wr_ana_lo) begin
                ana_cfg_q[15:0] <= reg_wdata;
            end
            if (wr_ana_hi) begin
                ana_cfg_q[N_PINS-1:16] <= reg_wdata[N_PINS-17:0];
            end
            if (wr_dir_lo) begin
                dir_q[15:0] <= reg_wdata;
            end
            if (wr_dir_hi) begin
                dir_q[N_PINS-1:16] <= reg_wdata[N_PINS-17:0];
            end
        end
    end

    // digital buffer off while analog: reads give zero
    // the same gated value feeds the remapped inputs, so analog pins stay quiet
    wire logic [N_PINS-1:0] dig_in = pin_sync_q & ana_cfg_q;

    // ------------------------------------------------------------
    // routing and pin ownership
    // ------------------------------------------------------------
    wire logic [4:0] irq1_sel = in_map_q[IN_IDX_IRQ1][12:8];
    wire logic [4:0] irq2_sel = in_map_q[IN_IDX_IRQ2][4:0];

    // analog first, then a remapped output, then the plain port
    // a field of 00000 means no peripheral: the pin stays on its port
    logic [N_PINS-1:0] per_own_d;
    always_comb begin
        per_own_d = '0;
        for (int p = 0; p < N_PINS; p++) begin
            if (p % 2 == 0) begin
                per_own_d[p] = out_map_q[p / 2][4:0] != OUT_SEL_NULL;
            end else begin
                per_own_d[p] = out_map_q[p / 2][12:8] != OUT_SEL_NULL;
            end
        end
        per_own_d = per_own_d & ana_cfg_q;
    end

    // routed and ownership outputs, all registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq1_q <= 1'b0;
            irq2_q <= 1'b0;
            ana_own_q <= '0;
            per_own_q <= '0;
            mism_q <= 1'b0;
        end else begin
            irq1_q <= pick_pin(irq1_sel, dig_in, dir_q);
            irq2_q <= pick_pin(irq2_sel, dig_in, dir_q);
            ana_own_q <= ~ana_cfg_q;
            per_own_q <= per_own_d;
            mism_q <= mism_any;
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    wire logic wr_clr = reg_wr && reg_addr == A_IRQ_CLR;
    wire logic wr_en = reg_wr && reg_addr == A_IRQ_EN;
    // each event lands on its named status bit, so the layout lives in one place
    wire logic [N_EV-1:0] ev_now;
    assign ev_now[EV_LOCKED_WR] = wr_map && lock_q;
    assign ev_now[EV_SEQ_ABORT] = seq_abort;
    assign ev_now[EV_MISMATCH] = mism_any;
    assign ev_now[EV_LOCK_CHG] = lock_upd;
    wire logic [N_EV-1:0] clr_bits = wr_clr ? reg_wdata[N_EV-1:0] : '0;
    // a fresh event beats a clear in the same cycle
    wire logic [N_EV-1:0] ev_stat_d = (ev_stat_q & ~clr_bits) | ev_now;

    // irq looks at next-state status and the incoming mask, so a new event
    // or a new enable shows on the pin one cycle later, not two
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ev_stat_q <= '0;
            ev_en_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ev_stat_q <= ev_stat_d;
            if (wr_en) begin
                ev_en_q <= reg_wdata[N_EV-1:0];
            end
            irq_q <= |(ev_stat_d & (wr_en ? reg_wdata[N_EV-1:0] : ev_en_q));
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_in) begin
            rd_mux = in_map_q[in_off[3:0]];
        end else if (hit_out) begin
            rd_mux = out_map_q[out_off[3:0]];
        end else begin
            case (reg_addr)
                A_OSC_CTL: rd_mux[LOCK_BIT] = lock_q;
                A_INFO: rd_mux = {13'h0000, seq_q, one_sess_q};
                A_IRQ_STAT: rd_mux = {12'h000, ev_stat_q};
                A_IRQ_CLR: rd_mux = 16'h0000; // write-only, reads as zero
                A_IRQ_EN: rd_mux = {12'h000, ev_en_q};
                A_ANA_LO: rd_mux = ana_cfg_q[15:0];
                A_ANA_HI: rd_mux = {6'h00, ana_cfg_q[N_PINS-1:16]};
                A_DIR_LO: rd_mux = dir_q[15:0];
                A_DIR_HI: rd_mux = {6'h00, dir_q[N_PINS-1:16]};
                A_PIN_LO: rd_mux = dig_in[15:0];
                A_PIN_HI: rd_mux = {6'h00, dig_in[N_PINS-1:16]};
                default: rd_mux = 16'h0000;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    // zero outside that cycle keeps a stale value from looking like an answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign remap_write_lock = lock_q;
    assign cfg_mismatch_rst = mism_q;
    assign ext_irq1_in = irq1_q;
    assign ext_irq2_in = irq2_q;
    assign pin_analog_own = ana_own_q;
    assign pin_periph_own = per_own_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

/* design/prlc_pkg.sv */
/*
 * prlc_pkg: shared constants for the pin remap lock control block.
 * assumes a 16-bit register port with word addresses of 8 bits.
 */
package prlc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int N_IN_MAP = 14;
    localparam int N_OUT_MAP = 13;
    localparam int N_PINS = 26;
    localparam logic [4:0] PIN_SEL_MAX = 5'h19;
    localparam logic [4:0] PIN_SEL_GND = 5'h1f;
    localparam logic [4:0] OUT_SEL_NULL = 5'h00;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_OSC_CTL = 8'h00;
    localparam logic [7:0] A_INFO = 8'h01;
    localparam logic [7:0] A_IRQ_STAT = 8'h02;
    localparam logic [7:0] A_IRQ_CLR = 8'h03;
    localparam logic [7:0] A_IRQ_EN = 8'h04;
    localparam logic [7:0] A_ANA_LO = 8'h08;
    localparam logic [7:0] A_ANA_HI = 8'h09;
    localparam logic [7:0] A_DIR_LO = 8'h0a;
    localparam logic [7:0] A_DIR_HI = 8'h0b;
    localparam logic [7:0] A_PIN_LO = 8'h0c;
    localparam logic [7:0] A_PIN_HI = 8'h0d;
    localparam logic [7:0] A_IN_MAP = 8'h20;
    localparam logic [7:0] A_OUT_MAP = 8'h40;

    // ------------------------------------------------------------
    // fields, keys and reset values
    // ------------------------------------------------------------
    localparam int LOCK_BIT = 6;
    localparam logic [7:0] KEY_FIRST = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;
    localparam logic LOCK_RST = 1'b0;
    localparam logic [15:0] MASK_HI_FIELD = 16'h1f00;
    localparam logic [15:0] MASK_LO_FIELD = 16'h001f;
    localparam logic [15:0] MASK_BOTH = 16'h1f1f;
    localparam int IN_IDX_IRQ1 = 0;
    localparam int IN_IDX_IRQ2 = 1;
    localparam int IN_IDX_LO_ONLY = 6;
    localparam logic [15:0] OUT_MAP_RST = 16'h0000;
    localparam logic [N_PINS-1:0] ANA_CFG_RST = 26'h0000000;
    localparam logic [N_PINS-1:0] DIR_RST = 26'h3ffffff;

    // interrupt status bits
    localparam int EV_LOCKED_WR = 0;
    localparam int EV_SEQ_ABORT = 1;
    localparam int EV_MISMATCH = 2;
    localparam int EV_LOCK_CHG = 3;
    localparam int N_EV = 4;

    // unlock sequence states
    typedef enum logic [1:0] {
        PRLC_SEQ_IDLE = 2'b00,
        PRLC_SEQ_KEY1 = 2'b01,
        PRLC_SEQ_ARMED = 2'b10
    } prlc_seq_t;
endpackage

/* verif/prlc_top_checker.sv */
/*
 * prlc_top_checker: port-level assertions for prlc_top.
 * assumes the bench changes the strap only while rst is high.
 */
`timescale 1ns/10ps
`default_nettype none
module prlc_top_checker
    import prlc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // strap and results
    input wire logic one_session_lock_cfg,
    input wire logic remap_write_lock,
    input wire logic cfg_mismatch_rst,
    input wire logic [N_PINS-1:0] pin_analog_own,
    input wire logic [N_PINS-1:0] pin_periph_own,
    input wire logic irq
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_lock_cause: assert property (
        $changed(remap_write_lock) |-> $past(reg_wr && reg_addr == A_OSC_CTL))
        else $error("lock moved without a control write");
    chk_lock_once: assert property (
        one_session_lock_cfg |-> !$fell(remap_write_lock))
        else $error("lock cleared in one-session mode");
    chk_lock_read: assert property (
        $past(reg_rd && reg_addr == A_OSC_CTL) |-> reg_rdata[LOCK_BIT] == remap_write_lock)
        else $error("lock bit read back wrong");
    chk_irq1_unused: assert property (
        $past(reg_rd && reg_addr == A_IN_MAP) |-> (reg_rdata & ~MASK_HI_FIELD) == 16'h0000)
        else $error("irq1 select spare bits not zero");
    chk_irq2_unused: assert property (
        $past(reg_rd && reg_addr == A_IN_MAP + 8'h01) |-> (reg_rdata & ~MASK_LO_FIELD) == 16'h0000)
        else $error("irq2 select spare bits not zero");
    chk_map_count: assert property (
        $past(reg_rd && (reg_addr == 8'h2e || reg_addr == 8'h4d)) |-> reg_rdata == 16'h0000)
        else $error("map register past the last one");
    chk_owner_excl: assert property (
        (pin_analog_own & pin_periph_own) == '0)
        else $error("pin owned by two functions");
    chk_analog_dflt: assert property (
        $fell(rst) |=> pin_analog_own == {N_PINS{1'b1}})
        else $error("pins not analog after reset");
    chk_no_mismatch: assert property (
        !cfg_mismatch_rst)
        else $error("shadow mismatch in normal run");

    // main scenarios reached
    cov_lock_set: cover property ($rose(remap_write_lock));
    cov_lock_clr: cover property ($fell(remap_write_lock));
    cov_irq: cover property ($rose(irq));
endmodule

bind prlc_top prlc_top_checker prlc_top_checker_inst (.ref_clk, .rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .one_session_lock_cfg, .remap_write_lock, .cfg_mismatch_rst,
    .pin_analog_own, .pin_periph_own, .irq);
`default_nettype wire

/* verif/prlc_top_bench.sv */
/*
 * prlc_top_bench: directed self-checking bench for prlc_top.
 * assumes the register port walk and pin latencies of the hand-over.
 */
`timescale 1ns/10ps
`default_nettype none
module prlc_top_bench
    import prlc_pkg::*;
();
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic one_session_lock_cfg = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] v;
    logic [N_PINS-1:0] pin_in = '0;
    logic [N_PINS-1:0] pin_analog_own;
    logic [N_PINS-1:0] pin_periph_own;
    logic remap_write_lock;
    logic cfg_mismatch_rst;
    logic ext_irq1_in;
    logic ext_irq2_in;
    logic irq;
    int fail_count = 0;
    int cmp_count = 0;

    prlc_top prlc_top_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .one_session_lock_cfg, .pin_in, .remap_write_lock, .cfg_mismatch_rst,
        .ext_irq1_in, .ext_irq2_in, .pin_analog_own, .pin_periph_own, .irq);

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] e, input string what);
        rd(a);
        check(what, v, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // two keys, then the lock update as one write
    task automatic key_seq(input logic [15:0] d);
        wr(A_OSC_CTL, {8'h00, KEY_FIRST});
        wr(A_OSC_CTL, {8'h00, KEY_SECOND});
        wr(A_OSC_CTL, d);
        settle(2);
    endtask

    task automatic do_reset(input logic strap);
        @(posedge ref_clk);
        rst <= 1'b1;
        one_session_lock_cfg <= strap;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        settle(2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] e;
        check("analog_own", pin_analog_own, {N_PINS{1'b1}});
        for (int i = 0; i < N_IN_MAP; i++) begin
            e = (i == IN_IDX_IRQ1) ? MASK_HI_FIELD : MASK_BOTH;
            e = (i == IN_IDX_IRQ2 || i == IN_IDX_LO_ONLY) ? MASK_LO_FIELD : e;
            chk_reg(A_IN_MAP + 8'(i), e, "in_map");
        end
        for (int i = 0; i < N_OUT_MAP; i++) begin
            chk_reg(A_OUT_MAP + 8'(i), OUT_MAP_RST, "out_map");
        end
        chk_reg(A_IN_MAP + 8'(N_IN_MAP), 16'h0000, "in_map_end");
        chk_reg(A_OUT_MAP + 8'(N_OUT_MAP), 16'h0000, "out_map_end");
        rd(A_OSC_CTL);
        check("lock_bit", v[LOCK_BIT], LOCK_RST);
    endtask

    task automatic t_lock();
        wr(A_IN_MAP, 16'hffff);
        chk_reg(A_IN_MAP, MASK_HI_FIELD, "irq1_sel");
        key_seq(16'h0040);
        check("lock_set", remap_write_lock, 1'b1);
        wr(A_IN_MAP, 16'h0300);
        wr(A_OUT_MAP, 16'h0303);
        chk_reg(A_IN_MAP, MASK_HI_FIELD, "locked_in");
        chk_reg(A_OUT_MAP, 16'h0000, "locked_out");
        rd(A_IRQ_STAT);
        check("locked_evt", v[EV_LOCKED_WR], 1'b1);
        check("lock_evt", v[EV_LOCK_CHG], 1'b1);
        check("lock_held", remap_write_lock, 1'b1);
        key_seq(16'h0000);
        check("unlock", remap_write_lock, 1'b0);
        wr(A_IN_MAP, 16'h0300);
        wr(A_IN_MAP + 8'h01, 16'hffff);
        chk_reg(A_IN_MAP, 16'h0300, "open_in");
        chk_reg(A_IN_MAP + 8'h01, MASK_LO_FIELD, "irq2_sel");
    endtask

    // keys reversed: neither the reversed key order nor the stray byte after it may arm the update
    task automatic t_abort();
        wr(A_OSC_CTL, {8'h00, KEY_SECOND});
        wr(A_OSC_CTL, {8'h00, KEY_FIRST});
        wr(A_OSC_CTL, 16'h0040);
        settle(2);
        check("abort_lock", remap_write_lock, 1'b0);
        rd(A_IRQ_STAT);
        check("abort_evt", v[EV_SEQ_ABORT], 1'b1);
    endtask

    task automatic t_pins();
        pin_in <= '1;
        settle(4);
        chk_reg(A_PIN_LO, 16'h0000, "analog_read");
        check("irq1_analog", ext_irq1_in, 1'b0);
        wr(A_ANA_LO, 16'hffff);
        wr(A_ANA_HI, 16'h03ff);
        settle(4);
        check("irq1_pin3", ext_irq1_in, 1'b1);
        chk_reg(A_PIN_HI, 16'h03ff, "digital_read");
        wr(A_IN_MAP, {3'b000, PIN_SEL_GND, 8'h00});
        settle(3);
        check("irq1_gnd", ext_irq1_in, 1'b0);
        wr(A_IN_MAP + 8'h01, {11'h000, PIN_SEL_MAX});
        settle(3);
        check("irq2_pin25", ext_irq2_in, 1'b1);
        wr(A_DIR_HI, 16'h0000);
        settle(3);
        check("irq2_output", ext_irq2_in, 1'b0);
    endtask

    task automatic t_out();
        wr(A_OUT_MAP, 16'h0003);
        settle(3);
        check("periph_own", pin_periph_own[1:0], 2'b01);
        wr(A_ANA_LO, 16'hfffe);
        settle(3);
        check("analog_wins", {pin_analog_own[0], pin_periph_own[0]}, 2'b10);
    endtask

    task automatic t_irq();
        wr(A_IRQ_CLR, 16'h000f);
        wr(A_IRQ_EN, 16'h0001);
        key_seq(16'h0040);
        wr(A_OUT_MAP, 16'h0000);
        settle(2);
        check("irq_raise", irq, 1'b1);
        wr(A_IRQ_EN, 16'h0000);
        settle(2);
        check("irq_mask", irq, 1'b0);
        wr(A_IRQ_EN, 16'h0001);
        wr(A_IRQ_CLR, 16'h0001);
        settle(2);
        check("irq_clear", irq, 1'b0);
        rd(A_IRQ_STAT);
        check("mism_evt", v[EV_MISMATCH], 1'b0);
        check("mism_rst", cfg_mismatch_rst, 1'b0);
        key_seq(16'h0000);
    endtask

    // one-session strap: lock may be set but never cleared until reset
    task automatic t_once();
        do_reset(1'b1);
        rd(A_INFO);
        check("strap", v[0], 1'b1);
        key_seq(16'h0040);
        check("once_set", remap_write_lock, 1'b1);
        key_seq(16'h0000);
        check("once_hold", remap_write_lock, 1'b1);
        wr(A_IN_MAP, 16'h0000);
        chk_reg(A_IN_MAP, MASK_HI_FIELD, "once_in");
        do_reset(1'b1);
        check("once_reset", remap_write_lock, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        settle(2);
        t_reset();
        t_lock();
        t_abort();
        t_pins();
        t_out();
        t_irq();
        t_once();
        stop_test();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
